/* File: hw/wdt_pkg.sv */
// shared constants and types for the system watchdog timer
// assumes a 32-bit apb slave port and a single core clock domain
package wdt_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] COUNT_OFS = 8'h0c;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_ENH_BIT = 0;
   localparam int CTRL_SEL_LO = 1;
   localparam int CTRL_SEL_HI = 2;
   localparam int CTRL_REL_LO = 8;
   localparam int CTRL_REL_HI = 15;
   localparam int CMD_SERVICE_BIT = 0;
   localparam int CMD_DISABLE_BIT = 1;
   localparam int CMD_ENABLE_BIT = 2;
   localparam int CMD_END_OF_INIT_INSTRUCTION_BIT = 3;

   // ------------------------------------------------------------
   // reset values: divide by 2, reload 0 gives 131072 cycles
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_DIV2 = 2'h0;
   localparam logic [1:0] SEL_DIV4 = 2'h1;
   localparam logic [1:0] SEL_DIV128 = 2'h2;
   localparam logic [1:0] SEL_DIV256 = 2'h3;
   localparam logic [1:0] SEL_RESET = SEL_DIV2;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] LIM_DIV2 = 8'h01;
   localparam logic [7:0] LIM_DIV4 = 8'h03;
   localparam logic [7:0] LIM_DIV128 = 8'h7f;
   localparam logic [7:0] LIM_DIV256 = 8'hff;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [7:0] LOW_CLEAR = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [7:0] reload;
      logic [1:0] presSel;
      logic enhanced;
   } wdt_ctrl_t;

   function automatic logic [7:0] divLimit(input logic [1:0] sel);
      case (sel)
         SEL_DIV2: divLimit = LIM_DIV2;
         SEL_DIV4: divLimit = LIM_DIV4;
         SEL_DIV128: divLimit = LIM_DIV128;
         default: divLimit = LIM_DIV256;
      endcase
   endfunction : divLimit

endpackage : wdt_pkg

/* File: hw/wdt_prescaler.sv */
// clock prescaler: one-cycle tick every 2/4/128/256 core clocks
// assumes sel is stable while running; clear restarts the period
module wdt_prescaler (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic clear,
   input wire logic [1:0] sel,
   // tick out
   output logic tick
);
   import wdt_pkg::*;

   logic [7:0] div_ff;
   logic tick_ff;

   always_ff @(posedge core_clk) begin
      if (rst || clear || !run) begin
         div_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else if (div_ff >= divLimit(sel)) begin
         div_ff <= 8'h00;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end

   assign tick = tick_ff;

endmodule : wdt_prescaler

/* File: hw/system_watchdog_timer.sv */
// system watchdog timer with apb register access
// assumes a cpu-side apb master; the reset pulse goes to the chip reset logic
//
// Design decisions made here: the placing of the registers and the APB slave port.
module system_watchdog_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wdt_pkg::apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // watchdog outputs
   output logic hwResetReq,
   output logic wdtRunning
);
   import wdt_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   wdt_ctrl_t ctrl_ff;
   logic [15:0] cnt_ff;
   logic run_ff;
   logic initDone_ff;
   logic hwReset_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic tick;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic setup;
   logic wrAcc;
   logic cmdWr;
   logic svc;
   logic dis;
   logic ena;
   logic end_of_init_instruction;
   logic disOk;
   logic overflow;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == CTRL_OFS) || (a == CMD_OFS) || (a == STAT_OFS) || (a == COUNT_OFS);
   endfunction : mapped

   assign setup = apbReq.psel && !apbReq.penable;
   assign wrAcc = apbReq.psel && apbReq.penable && pready_ff && apbReq.pwrite;
   assign cmdWr = wrAcc && (apbReq.paddr == CMD_OFS);
   assign svc = cmdWr && apbReq.pwdata[CMD_SERVICE_BIT];
   assign dis = cmdWr && apbReq.pwdata[CMD_DISABLE_BIT];
   assign ena = cmdWr && apbReq.pwdata[CMD_ENABLE_BIT];
   assign end_of_init_instruction = cmdWr && apbReq.pwdata[CMD_END_OF_INIT_INSTRUCTION_BIT];
   // compatible mode: disable only while initialization is still open
   assign disOk = dis && (ctrl_ff.enhanced || !initDone_ff);
   // service beats a coinciding overflow tick, so a just-in-time service never resets the chip
   assign overflow = run_ff && tick && !svc && (cnt_ff == COUNT_MAX);

   // zero wait states: pready rises for the first access cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup && !mapped(apbReq.paddr);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup && !apbReq.pwrite) begin
         case (apbReq.paddr)
            CTRL_OFS: prdata_ff <= {16'h0000, ctrl_ff.reload, 5'h00, ctrl_ff.presSel,
                                    ctrl_ff.enhanced};
            STAT_OFS: prdata_ff <= {29'h0000_0000, hwReset_ff, initDone_ff, run_ff};
            COUNT_OFS: prdata_ff <= {16'h0000, cnt_ff};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_ff.reload <= RELOAD_RESET;
         ctrl_ff.presSel <= SEL_RESET;
         ctrl_ff.enhanced <= 1'b0;
      end else if (wrAcc && apbReq.paddr == CTRL_OFS) begin
         ctrl_ff.reload <= apbReq.pwdata[CTRL_REL_HI:CTRL_REL_LO];
         ctrl_ff.presSel <= apbReq.pwdata[CTRL_SEL_HI:CTRL_SEL_LO];
         ctrl_ff.enhanced <= apbReq.pwdata[CTRL_ENH_BIT];
      end
   end

   // ------------------------------------------------------------
   // enable and init state
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_ff <= 1'b1;
      end else if (disOk) begin
         run_ff <= 1'b0;
      end else if (ena) begin
         run_ff <= 1'b1;
      end
   end

   // one-way: only a chip reset reopens initialization
   always_ff @(posedge core_clk) begin
      if (rst) begin
         initDone_ff <= 1'b0;
      end else if (end_of_init_instruction) begin
         initDone_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // counter and overflow
   // ------------------------------------------------------------
   wdt_prescaler u_presc (
      .core_clk(core_clk),
      .rst(rst),
      .run(run_ff),
      .clear(svc),
      .sel(ctrl_ff.presSel),
      .tick(tick)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_ff <= {RELOAD_RESET, LOW_CLEAR};
      end else if (svc) begin
         cnt_ff <= {ctrl_ff.reload, LOW_CLEAR};
      end else if (overflow) begin
         cnt_ff <= {ctrl_ff.reload, LOW_CLEAR};
      end else if (run_ff && tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hwReset_ff <= 1'b0;
      end else begin
         hwReset_ff <= overflow;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign hwResetReq = hwReset_ff;
   assign wdtRunning = run_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_run_after_reset: assert property ($fell(rst) |-> run_ff && cnt_ff == 16'h0000)
      else $error("watchdog not running after reset");
   chk_compat_disable_lock: assert property (
      !ctrl_ff.enhanced && initDone_ff && dis && !ena && run_ff |=> run_ff)
      else $error("disable accepted after end of init in compatible mode");
   chk_compat_disable_early: assert property (!initDone_ff && dis |=> !run_ff)
      else $error("disable refused before end of init");
   chk_enh_disable: assert property (ctrl_ff.enhanced && dis |=> !run_ff)
      else $error("enhanced disable ignored");
   chk_enh_enable: assert property (ena && !dis |=> run_ff)
      else $error("enable ignored");
   chk_overflow_reset: assert property (
      run_ff && tick && !svc && cnt_ff == COUNT_MAX |=> hwResetReq ##1 !hwResetReq)
      else $error("overflow did not give one reset pulse");
   chk_reset_cause: assert property (
      hwResetReq |-> $past(run_ff) && $past(tick) && !$past(svc) && $past(cnt_ff) == COUNT_MAX)
      else $error("reset pulse without overflow");
   chk_stop_no_reset: assert property (!run_ff |=> !hwResetReq)
      else $error("reset pulse while stopped");
   chk_service_wins: assert property (svc |=> !hwResetReq)
      else $error("reset pulse despite service");
   chk_init_sticky: assert property (initDone_ff |=> initDone_ff)
      else $error("end of init state reopened");
   chk_service_reload: assert property (svc |=> cnt_ff == {$past(ctrl_ff.reload), 8'h00})
      else $error("service did not reload counter");
   chk_count_step: assert property (
      run_ff && tick && !svc && cnt_ff != COUNT_MAX |=> cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not step by one");
   chk_count_idle: assert property (
      !svc && !(run_ff && tick) |=> $stable(cnt_ff))
      else $error("counter moved without tick or service");
   // a ctrl write may change the divider under way, so writes are kept out of the window
   chk_div2_rate: assert property (
      run_ff && ctrl_ff.presSel == SEL_DIV2 && tick && !svc && !dis && !wrAcc
      ##1 !svc && !dis && !wrAcc |=> tick)
      else $error("divide by two tick rate wrong");
   chk_stop_hold: assert property (!run_ff && !svc |=> cnt_ff == $past(cnt_ff))
      else $error("counter moved while stopped");

   cov_overflow: cover property (hwResetReq);
   cov_service: cover property (svc && run_ff);
   cov_compat_lock: cover property (!ctrl_ff.enhanced && initDone_ff && dis && run_ff);
   cov_enh_cycle: cover property (ctrl_ff.enhanced && initDone_ff && dis ##[1:20] ena);

endmodule : system_watchdog_timer

/* File: verif/cpu_model.sv */
// cpu-side model: issues watchdog register accesses over apb
// assumes an apb slave on core_clk; every call starts one edge later
module cpu_model (
   // clock
   input wire logic core_clk,
   // apb master side
   output wdt_pkg::apb_req_t apbReq,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 100ps;
   import wdt_pkg::*;

   initial apbReq = '0;

   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   // request held until pready is sampled high; only the bench timeout ends a hung wait
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdat,
                       output logic [31:0] rdat, output logic err);
      @(posedge core_clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdat};
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      apbReq <= '0;
   endtask : xfer

   task automatic wr(input logic [7:0] addr, input logic [31:0] wdat);
      logic [31:0] d;
      logic e;
      xfer(1'b1, addr, wdat, d, e);
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [31:0] rdat, output logic err);
      xfer(1'b0, addr, 32'h0, rdat, err);
   endtask : rd

   // software restarts the watchdog well inside its interval
   task automatic service();
      wr(CMD_OFS, 32'h1 << CMD_SERVICE_BIT);
   endtask : service
endmodule : cpu_model

/* File: verif/tb_top.sv */
// self-checking bench for the system watchdog timer
// assumes hwResetReq is observed only, not fed back into rst
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wdt_pkg::*;

   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   localparam logic [31:0] DIS = 32'h1 << CMD_DISABLE_BIT;
   localparam logic [31:0] ENA = 32'h1 << CMD_ENABLE_BIT;
   logic core_clk;
   logic rst;
   apb_req_t apbReq;
   logic [31:0] prdata;
   logic pready, pslverr, hwResetReq, wdtRunning, err;
   logic [31:0] rdat, first;
   int numErrors = 0;
   int totalChecks = 0;
   int cycles = 0;
   int divs[3] = '{2, 4, 128};

   system_watchdog_timer u_dut (.core_clk(core_clk), .rst(rst), .apbReq(apbReq),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hwResetReq(hwResetReq),
      .wdtRunning(wdtRunning));
   cpu_model u_cpu (.core_clk(core_clk), .apbReq(apbReq), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic endOfTest();
      $display("checks %0d, errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : endOfTest

   // register updates land a cycle after the write; two negedges is safe
   task automatic running(input logic exp);
      repeat (2) @(negedge core_clk);
      check("running", {31'h0, exp}, {31'h0, wdtRunning});
   endtask : running

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic testReset();
      running(1'b1);
      u_cpu.rd(CTRL_OFS, rdat, err);
      check("ctrl defaults", 32'h0, rdat);
      u_cpu.rd(STAT_OFS, rdat, err);
      check("status after reset", 32'h1, rdat);
      u_cpu.rd(COUNT_OFS, rdat, err);
      check("count advancing", 32'h1, {31'h0, rdat != 32'h0});
   endtask : testReset

   task automatic testCompat();
      u_cpu.wr(CMD_OFS, DIS);
      running(1'b0);
      u_cpu.rd(COUNT_OFS, first, err);
      repeat (20) @(posedge core_clk);
      u_cpu.rd(COUNT_OFS, rdat, err);
      check("count frozen", first, rdat);
      u_cpu.wr(CMD_OFS, ENA);
      u_cpu.wr(CMD_OFS, 32'h1 << CMD_END_OF_INIT_INSTRUCTION_BIT);
      u_cpu.wr(CMD_OFS, DIS);
      running(1'b1);
      u_cpu.rd(STAT_OFS, rdat, err);
      check("status after init", 32'h3, rdat);
   endtask : testCompat

   task automatic testReload();
      u_cpu.wr(CTRL_OFS, 32'hab06);
      u_cpu.rd(CTRL_OFS, rdat, err);
      check("ctrl readback", 32'hab06, rdat);
      u_cpu.service();
      u_cpu.rd(COUNT_OFS, rdat, err);
      check("count after service", 32'hab00, rdat);
   endtask : testReload

   // reload ff leaves 256 ticks to the wrap; the pulse shows two edges after the last period
   task automatic testOverflow();
      int n;
      for (int s = 0; s < 3; s++) begin
         u_cpu.wr(CTRL_OFS, 32'hff00 | (s << CTRL_SEL_LO));
         u_cpu.service();
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (hwResetReq !== 1'b1 && n < 40000);
         check("cycles to overflow", 256 * divs[s] + 2, n);
         @(negedge core_clk);
         check("reset pulse width", 32'h0, {31'h0, hwResetReq});
         u_cpu.rd(COUNT_OFS, rdat, err);
         check("restart at reload", 32'hff, rdat[15:8]);
      end
   endtask : testOverflow

   task automatic testEnhanced();
      u_cpu.wr(CTRL_OFS, 32'h1 << CTRL_ENH_BIT);
      u_cpu.wr(CMD_OFS, DIS);
      running(1'b0);
      u_cpu.wr(CMD_OFS, ENA);
      running(1'b1);
      u_cpu.wr(CMD_OFS, DIS | ENA);
      running(1'b0);
      u_cpu.wr(CMD_OFS, ENA);
      u_cpu.rd(8'h10, rdat, err);
      check("unmapped error", 32'h1, {31'h0, err});
   endtask : testEnhanced

   // ------------------------------------------------------------
   // clock, reset, timeout and main sequence
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // whole run is about 35000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         numErrors++;
         endOfTest();
      end
   end

   initial begin
      rst = 1'b1;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      testReset();
      testCompat();
      testReload();
      testOverflow();
      testEnhanced();
      endOfTest();
   end
endmodule : tb_top
